// ==== hdl/dpi_defines.vh ====
// Timing, command and register constants for the DRAM power-up sequencer
`ifndef DPI_DEFINES_VH
`define DPI_DEFINES_VH
`define DPI_CLK_PERIOD_NS    20
`define DPI_RESET_HOLD_US    200
`define DPI_GATE_PRE_NS      10
`define DPI_GATE_POST_MS     2
`define DPI_STABLE_CLK_CYC   5
`define DPI_IDLE_FIRST_US    2
`define DPI_IMPEDANCE_CALIBRATION_US         1
`define DPI_LATCH_NS         30
`define DPI_LATCH_MIN_CYC    8
`define DPI_BOOT_PERIOD_NS   18
// Register byte offsets on the AXI4-Lite slave
`define DPI_REG_CTRL         5'h00
`define DPI_REG_STATUS       5'h04
`define DPI_REG_MR_ADDR      5'h08
`define DPI_REG_MR_DATA      5'h0C
`define DPI_REG_RD_DATA      5'h10
// Control bits
`define DPI_CTRL_START       0
`define DPI_CTRL_MRW         1
`define DPI_CTRL_MRR         2
`define DPI_CTRL_STEP        3
`define DPI_CTRL_ZQ_GRANT    4
// Mode register addresses in the device
`define DPI_MA_LATENCY       6'h02
`define DPI_MA_CMD_TRAIN     6'h0D
// Multipurpose command opcodes
`define DPI_MPC_ZQ_START     7'h4F
`define DPI_MPC_ZQ_LATCH     7'h51
`endif

// ==== hdl/dpi_init_ctrl.v ====
// Power-up initialization sequencer for a low-power x16 DRAM, with AXI4-Lite control
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`include "dpi_defines.vh"
module dpi_init_ctrl #(
  parameter RESET_HOLD_CYC = (`DPI_RESET_HOLD_US * 1000 + `DPI_CLK_PERIOD_NS - 1)
                             / `DPI_CLK_PERIOD_NS,
  parameter GATE_POST_CYC  = (`DPI_GATE_POST_MS * 1000000 + `DPI_CLK_PERIOD_NS - 1)
                             / `DPI_CLK_PERIOD_NS
) (
  input  wire        REF_CLK_I,
  input  wire        SRST_I,
  input  wire [4:0]  S_AXI_AWADDR_I,
  input  wire        S_AXI_AWVALID_I,
  output reg         S_AXI_AWREADY_O,
  input  wire [31:0] S_AXI_WDATA_I,
  input  wire [3:0]  S_AXI_WSTRB_I,
  input  wire        S_AXI_WVALID_I,
  output reg         S_AXI_WREADY_O,
  output reg  [1:0]  S_AXI_BRESP_O,
  output reg         S_AXI_BVALID_O,
  input  wire        S_AXI_BREADY_I,
  input  wire [4:0]  S_AXI_ARADDR_I,
  input  wire        S_AXI_ARVALID_I,
  output reg         S_AXI_ARREADY_O,
  output reg  [31:0] S_AXI_RDATA_O,
  output reg  [1:0]  S_AXI_RRESP_O,
  output reg         S_AXI_RVALID_O,
  input  wire        S_AXI_RREADY_I,
  input  wire        SUPPLY_OK_I,
  input  wire [7:0]  DQ_I,
  output reg         RESET_N_O,
  output reg         CKE_O,
  output reg         CS_O,
  output reg  [5:0]  CA_O
);

  localparam TICK_NS     = `DPI_CLK_PERIOD_NS;
  localparam PRE_CYC     = (`DPI_GATE_PRE_NS + TICK_NS - 1) / TICK_NS;
  localparam IDLE_CYC    = (`DPI_IDLE_FIRST_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam ZQ_CYC      = (`DPI_IMPEDANCE_CALIBRATION_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam LAT_NS_CYC  = (`DPI_LATCH_NS + TICK_NS - 1) / TICK_NS;
  localparam LAT_CYC     = (LAT_NS_CYC > `DPI_LATCH_MIN_CYC) ? LAT_NS_CYC
                           : `DPI_LATCH_MIN_CYC;
  // Each two-beat command occupies two cycles plus two deselects; a four-beat mode write fills all four
  localparam CMD_GAP     = 4;
  localparam [6:0] ZQ_START = `DPI_MPC_ZQ_START;
  localparam [6:0] ZQ_LATCH = `DPI_MPC_ZQ_LATCH;

  localparam S_RESET   = 12'h001;
  localparam S_PRE     = 12'h002;
  localparam S_POST    = 12'h004;
  localparam S_CKE     = 12'h008;
  localparam S_IDLE    = 12'h010;
  localparam S_CONFIG  = 12'h020;
  localparam S_ZQGRANT = 12'h040;
  localparam S_ZQWAIT  = 12'h080;
  localparam S_LATCH   = 12'h100;
  localparam S_TRAIN   = 12'h200;
  localparam S_READY   = 12'h400;
  localparam S_ISSUE   = 12'h800;

  reg  [11:0] state;
  reg  [11:0] ret_state;
  reg  [27:0] cnt;
  reg  [2:0]  phase;
  reg  [2:0]  stage;
  reg  [5:0]  cmd_a;
  reg  [5:0]  cmd_b;
  reg  [5:0]  cmd_c;
  reg  [5:0]  cmd_d;
  reg         four_beats;
  reg         supply_meta;
  reg         supply_ok;
  reg  [7:0]  dq_meta;
  reg  [7:0]  dq_sync;
  reg  [7:0]  rd_data;
  reg  [5:0]  mr_addr;
  reg  [7:0]  mr_data;
  reg         go;
  reg         mrw_req;
  reg         mrr_req;
  reg         step_req;
  reg         zq_grant;
  reg         busy;
  reg  [4:0]  wr_addr;
  reg  [31:0] wr_data;
  reg         aw_held;
  reg         w_held;

  // First two beats of a four-beat mode write; the top opcode bit rides on CA5
  function [11:0] mrw_pair;
    input [5:0] ma;
    input [7:0] op;
    begin
      mrw_pair = {{op[7], 5'b00110}, ma};
    end
  endfunction

  always @(posedge REF_CLK_I) begin
    supply_meta <= SUPPLY_OK_I;
    supply_ok   <= supply_meta;
    dq_meta     <= DQ_I;
    dq_sync     <= dq_meta;
  end

  // AXI4-Lite slave: address and data held until both have arrived
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O  <= 1'b0;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= 2'b00;
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RRESP_O   <= 2'b00;
      S_AXI_RDATA_O   <= 32'h00000000;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      wr_addr  <= 5'h00;
      wr_data  <= 32'h00000000;
      mr_addr  <= 6'h00;
      mr_data  <= 8'h00;
      go       <= 1'b0;
      mrw_req  <= 1'b0;
      mrr_req  <= 1'b0;
      step_req <= 1'b0;
      zq_grant <= 1'b0;
    end else begin
      S_AXI_AWREADY_O <= !aw_held && !S_AXI_AWREADY_O && !S_AXI_BVALID_O;
      S_AXI_WREADY_O  <= !w_held && !S_AXI_WREADY_O && !S_AXI_BVALID_O;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_held <= 1'b1;
        wr_addr <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_held  <= 1'b1;
        wr_data <= S_AXI_WDATA_I;
      end
      if (aw_held && w_held && !S_AXI_BVALID_O) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= 2'b00;
        case (wr_addr)
          `DPI_REG_CTRL: begin
            go       <= go | wr_data[`DPI_CTRL_START];
            mrw_req  <= mrw_req | wr_data[`DPI_CTRL_MRW];
            mrr_req  <= mrr_req | wr_data[`DPI_CTRL_MRR];
            step_req <= step_req | wr_data[`DPI_CTRL_STEP];
            zq_grant <= wr_data[`DPI_CTRL_ZQ_GRANT];
          end
          `DPI_REG_MR_ADDR: mr_addr <= wr_data[5:0];
          `DPI_REG_MR_DATA: mr_data <= wr_data[7:0];
          `DPI_REG_STATUS: begin
          end
          default: S_AXI_BRESP_O <= 2'b10;
        endcase
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
      S_AXI_ARREADY_O <= !S_AXI_ARREADY_O && !S_AXI_RVALID_O;
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RRESP_O  <= 2'b00;
        case (S_AXI_ARADDR_I)
          `DPI_REG_CTRL:    S_AXI_RDATA_O <= {27'h0, zq_grant, 4'h0};
          `DPI_REG_STATUS:  S_AXI_RDATA_O <= {17'h0, busy, 2'b00, state};
          `DPI_REG_MR_ADDR: S_AXI_RDATA_O <= {26'h0, mr_addr};
          `DPI_REG_MR_DATA: S_AXI_RDATA_O <= {24'h0, mr_data};
          `DPI_REG_RD_DATA: S_AXI_RDATA_O <= {24'h0, rd_data};
          default: begin
            S_AXI_RDATA_O <= 32'h00000000;
            S_AXI_RRESP_O <= 2'b10;
          end
        endcase
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
      // Requests clear when the sequencer takes them; a new write wins, except for start, whose clear wins
      // Start stays pending until the hold time has run out
      if (state == S_PRE && go)
        go <= 1'b0;
      if ((state == S_CONFIG || state == S_TRAIN || state == S_READY) && mrw_req
          && !(aw_held && w_held))
        mrw_req <= 1'b0;
      if (state == S_CONFIG && !mrw_req && mrr_req && !(aw_held && w_held))
        mrr_req <= 1'b0;
      if ((state == S_CONFIG || state == S_TRAIN) && !mrw_req && !mrr_req && step_req
          && !(aw_held && w_held))
        step_req <= 1'b0;
    end
  end

  // Sequencer: each wait counts whole cycles, rounded up
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      state      <= S_RESET;
      ret_state  <= S_RESET;
      cnt        <= 28'h0000000;
      phase      <= 3'h0;
      stage      <= 3'h0;
      cmd_a      <= 6'h00;
      cmd_b      <= 6'h00;
      cmd_c      <= 6'h00;
      cmd_d      <= 6'h00;
      four_beats <= 1'b0;
      rd_data    <= 8'h00;
      busy       <= 1'b0;
      RESET_N_O  <= 1'b0;
      CKE_O      <= 1'b0;
      CS_O       <= 1'b0;
      CA_O       <= 6'h00;
    end else begin
      case (state)
        S_RESET: begin
          RESET_N_O <= 1'b0;
          CKE_O     <= 1'b0;
          busy      <= go;
          if (!supply_ok)
            cnt <= 28'h0000000;
          else if (cnt < RESET_HOLD_CYC)
            cnt <= cnt + 28'h0000001;
          else if (go) begin
            cnt   <= 28'h0000000;
            state <= S_PRE;
          end
        end
        S_PRE: begin
          // Clock enable already low; hold before releasing reset
          if (cnt + 28'h0000001 < PRE_CYC + 1)
            cnt <= cnt + 28'h0000001;
          else begin
            RESET_N_O <= 1'b1;
            cnt       <= 28'h0000000;
            state     <= S_POST;
          end
        end
        S_POST: begin
          if (cnt < GATE_POST_CYC)
            cnt <= cnt + 28'h0000001;
          else begin
            cnt   <= 28'h0000000;
            state <= S_CKE;
          end
        end
        S_CKE: begin
          // Clock has run free since reset; count extra cycles anyway
          CS_O <= 1'b0;
          if (cnt < `DPI_STABLE_CLK_CYC)
            cnt <= cnt + 28'h0000001;
          else begin
            CKE_O <= 1'b1;
            cnt   <= 28'h0000000;
            state <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (cnt < IDLE_CYC)
            cnt <= cnt + 28'h0000001;
          else begin
            cnt   <= 28'h0000000;
            state <= S_CONFIG;
          end
        end
        S_CONFIG: begin
          // Software writes drive/termination settings, then steps on
          // Read data settles after the sync flops, so keep sampling here
          rd_data <= dq_sync;
          if (mrw_req) begin
            {cmd_a, cmd_b} <= mrw_pair(mr_addr, mr_data);
            cmd_c      <= {mr_data[6], 5'b10110};
            cmd_d      <= mr_data[5:0];
            four_beats <= 1'b1;
            ret_state  <= S_CONFIG;
            state      <= S_ISSUE;
          end else if (mrr_req) begin
            cmd_a      <= 6'b001110;
            cmd_b      <= mr_addr;
            four_beats <= 1'b0;
            ret_state  <= S_CONFIG;
            state      <= S_ISSUE;
          end else if (step_req)
            state <= S_ZQGRANT;
        end
        S_ZQGRANT: begin
          // Shared resistor: software grants exclusive calibration slot
          if (zq_grant) begin
            cmd_a      <= {ZQ_START[6], 5'b00000};
            cmd_b      <= ZQ_START[5:0];
            four_beats <= 1'b0;
            ret_state  <= S_ZQWAIT;
            state      <= S_ISSUE;
          end
        end
        S_ZQWAIT: begin
          if (cnt < ZQ_CYC)
            cnt <= cnt + 28'h0000001;
          else begin
            cnt        <= 28'h0000000;
            cmd_a      <= {ZQ_LATCH[6], 5'b00000};
            cmd_b      <= ZQ_LATCH[5:0];
            four_beats <= 1'b0;
            ret_state  <= S_LATCH;
            state      <= S_ISSUE;
          end
        end
        S_LATCH: begin
          if (cnt < LAT_CYC)
            cnt <= cnt + 28'h0000001;
          else begin
            cnt   <= 28'h0000000;
            stage <= 3'h0;
            state <= S_TRAIN;
          end
        end
        S_TRAIN: begin
          // Stage 0 command bus, 1 write leveling, 2 moves on to ready without a command
          rd_data <= dq_sync;
          if (mrw_req || step_req) begin
            if (stage == 3'h2)
              state <= S_READY;
            else begin
              stage <= stage + 3'h1;
              {cmd_a, cmd_b} <= mrw_pair((stage == 3'h0) ? `DPI_MA_CMD_TRAIN
                                         : `DPI_MA_LATENCY, mr_data);
              cmd_c      <= {mr_data[6], 5'b10110};
              cmd_d      <= mr_data[5:0];
              four_beats <= 1'b1;
              ret_state  <= S_TRAIN;
              state      <= S_ISSUE;
            end
          end
        end
        S_READY: begin
          busy    <= 1'b0;
          rd_data <= dq_sync;
          if (mrw_req) begin
            {cmd_a, cmd_b} <= mrw_pair(mr_addr, mr_data);
            cmd_c      <= {mr_data[6], 5'b10110};
            cmd_d      <= mr_data[5:0];
            four_beats <= 1'b1;
            ret_state  <= S_READY;
            state      <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          // Beats at boot clock; 20 ns exceeds the 18 ns minimum
          phase <= phase + 3'h1;
          case (phase)
            3'h0: begin CS_O <= 1'b1; CA_O <= cmd_a; end
            3'h1: begin CS_O <= 1'b0; CA_O <= cmd_b; end
            3'h2: begin CS_O <= four_beats; CA_O <= four_beats ? cmd_c : 6'h00; end
            3'h3: begin CS_O <= 1'b0; CA_O <= four_beats ? cmd_d : 6'h00; end
            default: begin
              CS_O  <= 1'b0;
              CA_O  <= 6'h00;
              phase <= 3'h0;
              if (ret_state == S_READY || ret_state == S_CONFIG)
                rd_data <= dq_sync;
              state <= ret_state;
            end
          endcase
        end
        default: state <= S_RESET;
      endcase
    end
  end

endmodule // dpi_init_ctrl

// ==== verification/dpi_dram_model.sv ====
// Behavioural model of the DRAM seen by the sequencer
`include "dpi_defines.vh"
module dpi_dram_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       cke_i,
  input  wire logic       cs_i,
  input  wire logic [5:0] ca_i,
  output logic      [7:0] dq_o
);
  logic [7:0] mr [0:63];
  logic [7:0] rd;
  logic [7:0] pat = 8'h5A;
  logic [5:0] beat1, ma;
  logic       pend, op7, rd_on, cal_applied;
  int         n_mrw, n_mrr, n_zq_start, n_zq_latch;
  wire        cbt_mode = mr[13][0];
  wire        wl_mode  = mr[2][7];
  wire  [6:0] mpc_op   = {beat1[5], ca_i};
  // No array is modelled, so training never disturbs stored data
  // Released bus has no pull: show a changing pattern, not a held value
  always @(posedge clk_i) pat <= ~pat;
  always_comb dq_o = !rst_n_i ? pat : cbt_mode ? {2'b00, ca_i} : rd_on ? rd : pat;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 64; i++)
        mr[i] <= 8'h00;
      mr[12] <= 8'h4D;
      mr[14] <= 8'h4D;
      pend <= 1'b0;
      rd_on <= 1'b0;
      cal_applied <= 1'b0;
      n_mrw <= 0;
      n_mrr <= 0;
      n_zq_start <= 0;
      n_zq_latch <= 0;
    end else if (cke_i) begin
      pend <= cs_i;
      if (cs_i) begin
        beat1 <= ca_i;
        rd_on <= 1'b0;
      end else if (pend) begin
        case (beat1[4:0])
          5'h06: begin
            ma <= ca_i;
            op7 <= beat1[5];
          end
          5'h16: begin
            mr[ma] <= {op7, beat1[5], ca_i};
            n_mrw <= n_mrw + 1;
          end
          5'h0E: begin
            rd <= mr[ca_i];
            rd_on <= 1'b1;
            n_mrr <= n_mrr + 1;
          end
          5'h00: begin
            if (mpc_op == `DPI_MPC_ZQ_START)
              n_zq_start <= n_zq_start + 1;
            if (mpc_op == `DPI_MPC_ZQ_LATCH) begin
              n_zq_latch <= n_zq_latch + 1;
              cal_applied <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule // dpi_dram_model

// ==== verification/dpi_init_chk.sv ====
// Port assertions for the DRAM power-up sequencer
`include "dpi_defines.vh"
module dpi_init_chk #(
  parameter RESET_HOLD_CYC = 10000,
  parameter GATE_POST_CYC  = 100000
) (
  input wire       REF_CLK_I,
  input wire       SRST_I,
  input wire       SUPPLY_OK_I,
  input wire       RESET_N_O,
  input wire       CKE_O,
  input wire       CS_O,
  input wire [5:0] CA_O
);
  localparam int IDLE_CYC = 100;
  localparam int ZQ_CYC   = 50;
  localparam int LAT_CYC  = 8;
  logic [17:0] sup_cnt, rel_cnt, cke_cnt, zq_cnt, lat_cnt;
  logic [5:0]  first_ca;
  logic        second;
  wire  [6:0]  mpc_code = {first_ca[5], CA_O};
  wire         mpc_hit  = second && (first_ca[4:0] == 5'h00);
  function automatic logic [17:0] inc(input logic [17:0] v);
    return (v == 18'h3FFFF) ? v : v + 18'h1;
  endfunction
  // Latch gap starts at two so it counts from the command's first beat
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      sup_cnt <= 18'h0;
      rel_cnt <= 18'h0;
      cke_cnt <= 18'h0;
      zq_cnt <= 18'h0;
      lat_cnt <= 18'h3FFFF;
      second <= 1'b0;
      first_ca <= 6'h00;
    end else begin
      sup_cnt <= SUPPLY_OK_I ? inc(sup_cnt) : 18'h0;
      rel_cnt <= RESET_N_O ? inc(rel_cnt) : 18'h0;
      cke_cnt <= CKE_O ? inc(cke_cnt) : 18'h0;
      second <= CS_O;
      first_ca <= CA_O;
      if (mpc_hit && mpc_code == `DPI_MPC_ZQ_START)
        zq_cnt <= 18'h1;
      else if (zq_cnt != 18'h0)
        zq_cnt <= inc(zq_cnt);
      lat_cnt <= (mpc_hit && mpc_code == `DPI_MPC_ZQ_LATCH) ? 18'h2 : inc(lat_cnt);
    end
  end
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);
  property p_hold_reset; $rose(RESET_N_O) |-> sup_cnt >= RESET_HOLD_CYC; endproperty
  a_hold_reset: assert property (p_hold_reset) else $error("reset released early");
  property p_reset_out; $fell(SRST_I) |-> !RESET_N_O && !CKE_O && !CS_O; endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs active after reset");
  property p_gate_pre; $rose(RESET_N_O) |-> !CKE_O && !$past(CKE_O); endproperty
  a_gate_pre: assert property (p_gate_pre) else $error("clock enable high at release");
  property p_gate_post; $rose(CKE_O) |-> rel_cnt >= GATE_POST_CYC; endproperty
  a_gate_post: assert property (p_gate_post) else $error("clock enable raised early");
  property p_gate_cs; $rose(CKE_O) |-> !CS_O [*4]; endproperty
  a_gate_cs: assert property (p_gate_cs) else $error("select high at enable rise");
  property p_cke_rst; CKE_O |-> RESET_N_O; endproperty
  a_cke_rst: assert property (p_cke_rst) else $error("clock enable while in reset");
  property p_idle; $rose(CS_O) |-> CKE_O && cke_cnt >= IDLE_CYC; endproperty
  a_idle: assert property (p_idle) else $error("command too soon after enable");
  property p_zq_gap; mpc_hit && mpc_code == `DPI_MPC_ZQ_LATCH |-> zq_cnt >= ZQ_CYC; endproperty
  a_zq_gap: assert property (p_zq_gap) else $error("latch too soon after start");
  property p_latch_quiet; CS_O |-> lat_cnt >= LAT_CYC; endproperty
  a_latch_quiet: assert property (p_latch_quiet) else $error("command inside latch gap");
  property p_cs_pulse; CS_O |=> !CS_O; endproperty
  a_cs_pulse: assert property (p_cs_pulse) else $error("select held two cycles");
endmodule // dpi_init_chk
bind dpi_init_ctrl dpi_init_chk #(
  .RESET_HOLD_CYC(RESET_HOLD_CYC),
  .GATE_POST_CYC (GATE_POST_CYC)
) u_dpi_init_chk (
  .REF_CLK_I  (REF_CLK_I),
  .SRST_I     (SRST_I),
  .SUPPLY_OK_I(SUPPLY_OK_I),
  .RESET_N_O  (RESET_N_O),
  .CKE_O      (CKE_O),
  .CS_O       (CS_O),
  .CA_O       (CA_O)
);

// ==== verification/dpi_init_ctrl_tb.sv ====
// Self-checking bench for the DRAM power-up sequencer
`include "dpi_defines.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %0t: got %h expected %h", $time, (g), (e)); end end
module dpi_init_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  localparam int GATE = 30;
  typedef struct packed {logic [4:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} dpi_row_t;
  dpi_row_t rows [4] = '{'{`DPI_REG_MR_ADDR, 32'h0D, 32'h0D, 2'b00},
    '{`DPI_REG_MR_DATA, 32'hA5, 32'hA5, 2'b00}, '{5'h14, 32'h5A, 32'h0, 2'b10},
    '{5'h1C, 32'h3C, 32'h0, 2'b10}};
  logic [13:0] dflt [7] = '{14'h0100, 14'h0200, 14'h0300, 14'h0B00, 14'h0C4D, 14'h0D00, 14'h0E4D};
  logic        clk, srst, supply, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, rst_n, cke, cs;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [5:0]  ca, ca_snap;
  logic [7:0]  dq;
  int          bad_count, n_compared, cyc, t0, n;
  dpi_init_ctrl #(.RESET_HOLD_CYC(HOLD), .GATE_POST_CYC(GATE)) u_dpi_init_ctrl (
    .REF_CLK_I(clk), .SRST_I(srst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .SUPPLY_OK_I(supply), .DQ_I(dq), .RESET_N_O(rst_n), .CKE_O(cke), .CS_O(cs), .CA_O(ca));
  dpi_dram_model u_dpi_dram_model (.clk_i(clk), .rst_n_i(rst_n), .cke_i(cke), .cs_i(cs),
    .ca_i(ca), .dq_o(dq));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (1) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [4:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (1) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    q = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Waits for the model to decode the command, then for the two sync flops
  task automatic mode_cmd(input logic [5:0] ma, input logic [7:0] op, input int bit_no);
    int n0;
    axi_wr(`DPI_REG_MR_ADDR, {26'h0, ma});
    axi_wr(`DPI_REG_MR_DATA, {24'h0, op});
    n0 = u_dpi_dram_model.n_mrw + u_dpi_dram_model.n_mrr;
    axi_wr(`DPI_REG_CTRL, 32'h1 << bit_no);
    while (u_dpi_dram_model.n_mrw + u_dpi_dram_model.n_mrr == n0) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("Error %0t: timeout", $time);
    print_verdict();
  end
  initial begin
    {srst, supply, awvalid, wvalid, bready, arvalid, rready} = 7'b1000000;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({rst_n, cke, cs}, 3'b000)
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].d);
      `CHK(r, rows[i].r)
      axi_rd(rows[i].a);
      `CHK({r, q}, {rows[i].r, rows[i].q})
    end
    supply <= 1'b1;
    t0 = cyc;
    axi_wr(`DPI_REG_CTRL, 32'h1);
    while (!rst_n) @(posedge clk);
    `CHK(cyc - t0 >= HOLD, 1'b1)
    `CHK(cke, 1'b0)
    t0 = cyc;
    while (!cke) @(posedge clk);
    `CHK(cyc - t0 >= GATE, 1'b1)
    `CHK(cs, 1'b0)
    foreach (dflt[i]) begin
      mode_cmd(dflt[i][13:8], 8'h00, `DPI_CTRL_MRR);
      axi_rd(`DPI_REG_RD_DATA);
      `CHK(q[7:0], dflt[i][7:0])
    end
    mode_cmd(6'h0B, 8'hC3, `DPI_CTRL_MRW);
    `CHK(u_dpi_dram_model.mr[11], 8'hC3)
    axi_wr(`DPI_REG_CTRL, 32'h1 << `DPI_CTRL_STEP);
    repeat (80) @(posedge clk);
    `CHK(u_dpi_dram_model.n_zq_start, 0)
    axi_wr(`DPI_REG_CTRL, 32'h1 << `DPI_CTRL_ZQ_GRANT);
    while (u_dpi_dram_model.n_zq_latch == 0) @(posedge clk);
    `CHK(u_dpi_dram_model.n_zq_start, 1)
    mode_cmd(`DPI_MA_CMD_TRAIN, 8'h01, `DPI_CTRL_MRW);
    ca_snap = ca;
    axi_rd(`DPI_REG_RD_DATA);
    `CHK(q[7:0], {2'b00, ca_snap})
    mode_cmd(`DPI_MA_LATENCY, 8'h80, `DPI_CTRL_MRW);
    `CHK(u_dpi_dram_model.wl_mode, 1'b1)
    axi_wr(`DPI_REG_CTRL, 32'h1 << `DPI_CTRL_STEP);
    n = 0;
    do begin
      axi_rd(`DPI_REG_STATUS);
      n++;
    end while (q[14] !== 1'b0 && n < 40);
    `CHK(q[14], 1'b0)
    mode_cmd(6'h0E, 8'h2A, `DPI_CTRL_MRW);
    `CHK(u_dpi_dram_model.mr[14], 8'h2A)
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({rst_n, cke}, 2'b00)
    print_verdict();
  end
endmodule // dpi_init_ctrl_tb
